// ---- dv/adc_cfg_checker.sv ----
// Concurrent checks on the ports of the converter configuration block
`timescale 1ns/1ps
module adc_cfg_checker (
	input wire clk_in,
	input wire rst_n_in,
	input wire awvalid_in,
	input wire awready_out,
	input wire wvalid_in,
	input wire wready_out,
	input wire bvalid_out,
	input wire arvalid_in,
	input wire arready_out,
	input wire rvalid_out,
	input wire rready_in,
	input wire [31:0] rdata_out,
	input wire conv_done_in,
	input wire dma_request_out,
	input wire hw_trigger_out,
	input wire [10:0] channel_enable_out,
	input wire [4:0] timer_one_compare_in,
	input wire timer_two_compare_two_in,
	input wire timer_thirteen_compare_one_in,
	input wire timer_fourteen_compare_one_in,
	input wire timer_one_trigger_out_in,
	input wire timer_two_trigger_out_in,
	input wire [1:0] external_line_in
);
	// ==========================================
	// Helper history of trigger pins
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire pin_any = |{timer_one_compare_in, timer_two_compare_two_in, timer_thirteen_compare_one_in,
		timer_fourteen_compare_one_in, timer_one_trigger_out_in, timer_two_trigger_out_in, external_line_in};
	reg [5:0] hist_q;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			hist_q <= 6'h00;
		else
			hist_q <= {hist_q[4:0], pin_any};
	end
	// ==========================================
	// Assertions
	a_write_resp_time: assert property (awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out)
		else $error("write response not two cycles after accept");
	a_busy_blocks_write: assert property (bvalid_out |-> !awready_out && !wready_out)
		else $error("write accepted while response pending");
	a_read_resp_time: assert property (arvalid_in && arready_out |=> rvalid_out)
		else $error("read data not one cycle after accept");
	a_read_data_holds: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
		else $error("read data changed before taken");
	a_reserved_top_zero: assert property (rvalid_out |-> rdata_out[31:29] == 3'h0)
		else $error("reserved top bits read nonzero");
	a_dma_needs_done: assert property (dma_request_out |-> $past(conv_done_in))
		else $error("dma request without finished conversion");
	a_trig_pulse_short: assert property (hw_trigger_out |=> !hw_trigger_out)
		else $error("trigger pulse longer than one cycle");
	a_trig_needs_pin: assert property (hw_trigger_out |-> hist_q[5:1] != 5'h00)
		else $error("trigger without a source pin rising");
	a_mask_nonzero: assert property (channel_enable_out != 11'h000)
		else $error("channel enable output empty");
	c_write: cover property (bvalid_out);
	c_trigger: cover property (hw_trigger_out);
	c_dma: cover property (dma_request_out);
endmodule // adc_cfg_checker

bind adc_cfg_top adc_cfg_checker checker_i (.clk_in, .rst_n_in, .awvalid_in, .awready_out, .wvalid_in, .wready_out,
	.bvalid_out, .arvalid_in, .arready_out, .rvalid_out, .rready_in, .rdata_out, .conv_done_in, .dma_request_out,
	.hw_trigger_out, .channel_enable_out, .timer_one_compare_in, .timer_two_compare_two_in,
	.timer_thirteen_compare_one_in, .timer_fourteen_compare_one_in, .timer_one_trigger_out_in,
	.timer_two_trigger_out_in, .external_line_in);

// ---- dv/tb.sv ----
// Register and event tests of the converter configuration block
`timescale 1ns/1ps
module tb;
	logic clk_in = 0, rst_n_in = 0, awvalid_in = 0, wvalid_in = 0, bready_in = 0, arvalid_in = 0, rready_in = 0;
	logic [7:0] awaddr_in = 0, araddr_in = 0;
	logic [31:0] wdata_in = 0;
	logic [3:0] wstrb_in = 4'hf, conv_channel_in = 0, current_channel_in = 0, data_read_channel_in = 0;
	logic conv_done_in = 0, seq_done_in = 0, busy_in = 0, data_read_in = 0;
	logic [11:0] conv_result_in = 0, fire = 0;
	wire awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	wire hw_trigger_out, dma_request_out, irq_out, scan_direction_out, trigger_code_invalid_out;
	wire [1:0] bresp_out, rresp_out;
	wire [31:0] rdata_out;
	wire [10:0] channel_enable_out;
	wire [11:0] pins;
	int failures = 0, tests_run = 0, trig_count = 0, dma_count = 0;
	logic [1:0] r;
	logic [4:0] codes[13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0d, 5'h0f, 5'h10, 5'h11};
	int pinsel[13] = '{0, 1, 2, 5, 3, 10, 8, 6, 7, 9, 11, 3, 4};
	always #2.5 clk_in = ~clk_in;
	trigger_source_model src (.clk_in, .fire_in(fire), .pins_out(pins));
	adc_cfg_top DUT (.clk_in, .rst_n_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in, .wvalid_in,
		.wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out,
		.rresp_out, .rvalid_out, .rready_in, .timer_one_compare_in(pins[4:0]), .timer_two_compare_two_in(pins[5]),
		.timer_thirteen_compare_one_in(pins[6]), .timer_fourteen_compare_one_in(pins[7]),
		.timer_one_trigger_out_in(pins[8]), .timer_two_trigger_out_in(pins[9]), .external_line_in(pins[11:10]),
		.conv_done_in, .conv_channel_in, .conv_result_in, .seq_done_in, .busy_in, .current_channel_in,
		.data_read_in, .data_read_channel_in, .hw_trigger_out, .dma_request_out, .irq_out, .channel_enable_out,
		.scan_direction_out, .trigger_code_invalid_out);
	always @(posedge clk_in) begin
		if (hw_trigger_out === 1'b1) trig_count++;
		if (dma_request_out === 1'b1) dma_count++;
	end
	// ==========================================
	// Checking and closing
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================
	// Bus master: signals change only right after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ta, tw, tk, dn;
		@(posedge clk_in);
		awaddr_in <= a; wdata_in <= d; awvalid_in <= 1; wvalid_in <= 1; bready_in <= 1; dn = 0;
		while (!dn) begin
			@(negedge clk_in);
			ta = awvalid_in && awready_out; tw = wvalid_in && wready_out; tk = bvalid_out; rs = bresp_out;
			@(posedge clk_in);
			if (ta) awvalid_in <= 0;
			if (tw) wvalid_in <= 0;
			if (tk) begin bready_in <= 0; dn = 1; end
		end
	endtask
	// Read ready is offered with the address and held until valid is seen, as for the write response
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
		logic ta, tk, dn;
		logic [31:0] d;
		@(posedge clk_in);
		araddr_in <= a; arvalid_in <= 1; rready_in <= 1; dn = 0;
		while (!dn) begin
			@(negedge clk_in);
			ta = arvalid_in && arready_out; tk = rvalid_out && rready_in; d = rdata_out; r = rresp_out;
			@(posedge clk_in);
			if (ta) arvalid_in <= 0;
			if (tk) begin rready_in <= 0; dn = 1; end
		end
		chk(what, d & m, e);
	endtask
	// ==========================================
	// Event drivers
	task automatic conv(input logic [3:0] ch, input logic [11:0] res);
		@(posedge clk_in); conv_done_in <= 1; conv_channel_in <= ch; conv_result_in <= res;
		@(posedge clk_in); conv_done_in <= 0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic trig(input logic [4:0] c, input int p, input logic en, input int e);
		int n0;
		wr(8'h08, {13'h0, c[4:3], 10'h0, c[2:0], 1'b0, en, 2'h0}, r);
		n0 = trig_count;
		@(posedge clk_in); fire <= 12'h001 << p;
		repeat (3) @(posedge clk_in); fire <= 0;
		repeat (8) @(posedge clk_in);
		chk("trigger count", trig_count - n0, e);
	endtask
	// ==========================================
	// Tests
	initial begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1;
		chk("enable out", channel_enable_out, 32'h001);
		foreach (codes[i]) rdchk(8'h08 + 8'(i % 4) * 8'h04, 32'hffffffff, 32'h0, "reset value");
		wr(8'h08, 32'hffffffff, r); rdchk(8'h08, 32'hffffffff, 32'h0007f07f, "control");
		chk("scan dir", scan_direction_out, 1);
		wr(8'h0c, 32'hffffffff, r); rdchk(8'h0c, 32'hffffffff, 32'h7ff, "mask");
		chk("enable out", channel_enable_out, 32'h7ff);
		// The output register follows the mask one edge after the write lands
		wr(8'h0c, 32'h0, r); @(negedge clk_in);
		chk("enable out", channel_enable_out, 32'h001);
		wr(8'h10, 32'hffffffff, r); rdchk(8'h10, 32'hffffffff, 32'h0fff0fff, "thresholds");
		wr(8'h40, 32'h1, r); chk("write resp", r, 2);
		rdchk(8'h40, 32'hffffffff, 32'h0, "unmapped"); chk("read resp", r, 2);
		foreach (codes[i]) trig(codes[i], pinsel[i], 1, 1);
		trig(5'h05, 4, 1, 1);
		trig(5'h10, 0, 1, 0);
		trig(5'h00, 0, 0, 0); chk("code invalid", trigger_code_invalid_out, 0);
		trig(5'h04, 0, 1, 0); chk("code invalid", trigger_code_invalid_out, 1);
		wr(8'h08, 32'h8, r); wr(8'h10, 32'h08000100, r);
		busy_in <= 1; current_channel_in <= 5;
		conv(3, 12'h200); conv(3, 12'h200);
		chk("dma count", dma_count, 2);
		rdchk(8'h14, 32'hffffffff, 32'h00800854, "status");
		@(posedge clk_in); data_read_in <= 1; data_read_channel_in <= 3; busy_in <= 0;
		@(posedge clk_in); data_read_in <= 0;
		rdchk(8'h14, 32'hffffffff, 32'h00000050, "status");
		wr(8'h08, 32'h2002, r); conv(5, 12'h900); conv(2, 12'h500);
		rdchk(8'h14, 32'h3, 32'h0, "flags"); chk("dma count", dma_count, 2);
		conv(2, 12'h900); chk("irq", irq_out, 1);
		rdchk(8'h14, 32'h3, 32'h2, "flags");
		wr(8'h14, 32'h2, r); repeat (3) @(posedge clk_in); chk("irq", irq_out, 0);
		conv(2, 12'h0ff); rdchk(8'h14, 32'h3, 32'h2, "flags");
		wr(8'h08, 32'h2000, r); repeat (3) @(posedge clk_in); chk("irq", irq_out, 0);
		wr(8'h14, 32'h2, r);
		@(posedge clk_in); seq_done_in <= 1;
		@(posedge clk_in); seq_done_in <= 0;
		repeat (3) @(posedge clk_in); chk("irq", irq_out, 0);
		rdchk(8'h14, 32'h3, 32'h1, "flags");
		wr(8'h08, 32'h2001, r); repeat (3) @(posedge clk_in); chk("irq", irq_out, 1);
		wr(8'h14, 32'h1, r); repeat (3) @(posedge clk_in); chk("irq", irq_out, 0);
		rdchk(8'h14, 32'h3, 32'h0, "flags");
		complete_run;
	end
	// Tests need a few hundred cycles; this leaves a wide margin
	initial begin
		#100000;
		failures++;
		$display("BAD watchdog expected finish seen timeout");
		complete_run;
	end
endmodule // tb

// ---- dv/trigger_source_model.sv ----
// Timer and external-line trigger sources driving the converter trigger pins
`timescale 1ns/1ps
module trigger_source_model (
	input wire clk_in,
	input wire [11:0] fire_in,
	output reg [11:0] pins_out
);
	// Sources are logic outputs: low whenever not firing, so each rise is clean
	initial pins_out = 12'h000;
	always @(posedge clk_in) begin
		pins_out <= fire_in;
	end
endmodule // trigger_source_model

// ---- hw/adc_cfg_top.v ----
// Converter trigger, channel, watchdog and status configuration with AXI4-Lite slave
`timescale 1ns/1ps
`include "adc_cfg_regs.vh"
module adc_cfg_top (
	input wire clk_in,
	input wire rst_n_in,
	input wire [7:0] awaddr_in,
	input wire awvalid_in,
	output wire awready_out,
	input wire [31:0] wdata_in,
	input wire [3:0] wstrb_in,
	input wire wvalid_in,
	output wire wready_out,
	output reg [1:0] bresp_out,
	output reg bvalid_out,
	input wire bready_in,
	input wire [7:0] araddr_in,
	input wire arvalid_in,
	output wire arready_out,
	output reg [31:0] rdata_out,
	output reg [1:0] rresp_out,
	output reg rvalid_out,
	input wire rready_in,
	input wire [4:0] timer_one_compare_in,
	input wire timer_two_compare_two_in,
	input wire timer_thirteen_compare_one_in,
	input wire timer_fourteen_compare_one_in,
	input wire timer_one_trigger_out_in,
	input wire timer_two_trigger_out_in,
	input wire [1:0] external_line_in,
	input wire conv_done_in,
	input wire [3:0] conv_channel_in,
	input wire [11:0] conv_result_in,
	input wire seq_done_in,
	input wire busy_in,
	input wire [3:0] current_channel_in,
	input wire data_read_in,
	input wire [3:0] data_read_channel_in,
	output reg hw_trigger_out,
	output reg dma_request_out,
	output reg irq_out,
	output reg [10:0] channel_enable_out,
	output reg scan_direction_out,
	output reg trigger_code_invalid_out
);

	// ==========================================
	// Configuration registers
	reg [31:0] control_q;
	reg [31:0] channel_enable_mask_q;
	reg [31:0] watchdog_thresholds_q;

	wire [4:0] trigger_source_code;
	wire [2:0] trig_sel_low_part;
	wire [1:0] trig_sel_high_part;
	wire [3:0] watchdog_channel_select;
	wire [11:0] watchdog_high_threshold;
	wire [11:0] watchdog_low_threshold;

	assign trig_sel_low_part = control_q[`CTL_SEL_LO_MSB:`CTL_SEL_LO_LSB];
	assign trig_sel_high_part = control_q[`CTL_SEL_HI_MSB:`CTL_SEL_HI_LSB];
	assign trigger_source_code = {trig_sel_high_part, trig_sel_low_part};
	assign watchdog_channel_select = control_q[`CTL_WATCHDOG_CHANNEL_SELECT_MSB:`CTL_WATCHDOG_CHANNEL_SELECT_LSB];
	assign watchdog_high_threshold = watchdog_thresholds_q[27:16];
	assign watchdog_low_threshold = watchdog_thresholds_q[11:0];

	// ==========================================
	// Write channel: address and data taken in either order
	reg aw_have_q;
	reg [7:0] aw_addr_q;
	reg w_have_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire do_write;
	wire [31:0] byte_mask;
	wire [31:0] wr_bits;
	wire wr_hit;

	assign awready_out = ~aw_have_q & ~bvalid_out;
	assign wready_out = ~w_have_q & ~bvalid_out;
	assign do_write = aw_have_q & w_have_q & ~bvalid_out;
	assign byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_bits = w_data_q & byte_mask;
	assign wr_hit = (aw_addr_q == `OFF_CONTROL) || (aw_addr_q == `OFF_CHANNEL_ENABLE_MASK) ||
		(aw_addr_q == `OFF_WATCHDOG_THRESHOLDS) || (aw_addr_q == `OFF_CONVERSION_STATUS);

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_out <= 1'b0;
			bresp_out <= `RESP_OKAY;
		end else begin
			if (awvalid_in && awready_out) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {awaddr_in[7:2], 2'b00};
			end
			if (wvalid_in && wready_out) begin
				w_have_q <= 1'b1;
				w_data_q <= wdata_in;
				w_strb_q <= wstrb_in;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_out && bready_in) begin
				bvalid_out <= 1'b0;
			end
		end
	end

	wire wr_control;
	wire wr_mask;
	wire wr_thresh;
	wire wr_status;
	assign wr_control = do_write && (aw_addr_q == `OFF_CONTROL);
	assign wr_mask = do_write && (aw_addr_q == `OFF_CHANNEL_ENABLE_MASK);
	assign wr_thresh = do_write && (aw_addr_q == `OFF_WATCHDOG_THRESHOLDS);
	assign wr_status = do_write && (aw_addr_q == `OFF_CONVERSION_STATUS);

	// Reserved bits are masked off so they stay zero whatever is written
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			control_q <= `CONTROL_RESET;
			channel_enable_mask_q <= `MASK_RESET;
			watchdog_thresholds_q <= `THRESH_RESET;
		end else begin
			if (wr_control) begin
				control_q <= ((control_q & ~byte_mask) | wr_bits) & `CONTROL_WMASK;
			end
			// Not interlocked with busy; software keeps the mask still during conversion
			if (wr_mask) begin
				channel_enable_mask_q <= ((channel_enable_mask_q & ~byte_mask) | wr_bits) & `MASK_WMASK;
			end
			if (wr_thresh) begin
				watchdog_thresholds_q <= ((watchdog_thresholds_q & ~byte_mask) | wr_bits) & `THRESH_WMASK;
			end
		end
	end

	// ==========================================
	// Status flags
	wire eos_flag;
	wire awd_flag;
	wire eos_clear;
	wire awd_clear;
	wire awd_event;
	wire awd_channel_hit;
	wire awd_outside;

	assign eos_clear = wr_status & wr_bits[`STA_EOS];
	assign awd_clear = wr_status & wr_bits[`STA_AWD];
	assign awd_channel_hit = (conv_channel_in == watchdog_channel_select);
	assign awd_outside = (conv_result_in > watchdog_high_threshold) ||
		(conv_result_in < watchdog_low_threshold);
	assign awd_event = conv_done_in & awd_channel_hit & awd_outside;

	sticky_flag u_eos_flag (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.set_in(seq_done_in),
		.clear_in(eos_clear),
		.flag_out(eos_flag)
	);

	sticky_flag u_awd_flag (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.set_in(awd_event),
		.clear_in(awd_clear),
		.flag_out(awd_flag)
	);

	// Per-channel valid and overrun, cleared when that channel's data is read
	wire [10:0] valid_flags;
	wire [10:0] overrun_flags;
	genvar ch;
	generate
		for (ch = 0; ch < 11; ch = ch + 1) begin : g_chan
			wire done_here;
			wire read_here;
			assign done_here = conv_done_in && (conv_channel_in == ch);
			assign read_here = data_read_in && (data_read_channel_in == ch);
			sticky_flag u_valid (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.set_in(done_here),
				.clear_in(read_here),
				.flag_out(valid_flags[ch])
			);
			sticky_flag u_overrun (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.set_in(done_here & valid_flags[ch] & ~read_here),
				.clear_in(read_here),
				.flag_out(overrun_flags[ch])
			);
		end
	endgenerate

	// Only nine bit positions exist per field, so channels 9 and 10 are not visible
	wire [31:0] status_word;
	assign status_word = {3'h0, overrun_flags[8:0],
		3'h0, valid_flags[8:0],
		current_channel_in, 1'b0,
		busy_in,
		awd_flag, eos_flag};

	// ==========================================
	// Read channel
	reg [31:0] rd_word;
	reg rd_hit;
	assign arready_out = ~rvalid_out;

	always @* begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case ({araddr_in[7:2], 2'b00})
			`OFF_CONTROL: rd_word = control_q;
			`OFF_CHANNEL_ENABLE_MASK: rd_word = channel_enable_mask_q;
			`OFF_WATCHDOG_THRESHOLDS: rd_word = watchdog_thresholds_q;
			`OFF_CONVERSION_STATUS: rd_word = status_word;
			default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rvalid_out <= 1'b0;
			rdata_out <= 32'h00000000;
			rresp_out <= `RESP_OKAY;
		end else if (arvalid_in && arready_out) begin
			rvalid_out <= 1'b1;
			rdata_out <= rd_word;
			rresp_out <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_out && rready_in) begin
			rvalid_out <= 1'b0;
		end
	end

	// ==========================================
	// Trigger pins: two-flop synchroniser, then rising-edge detect
	wire [11:0] trig_pins;
	reg [11:0] trig_meta_q;
	reg [11:0] trig_sync_q;
	reg [11:0] trig_prev_q;
	wire [11:0] trig_rise;

	assign trig_pins = {external_line_in, timer_two_trigger_out_in, timer_one_trigger_out_in,
		timer_fourteen_compare_one_in, timer_thirteen_compare_one_in,
		timer_two_compare_two_in, timer_one_compare_in};

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trig_meta_q <= 12'h000;
			trig_sync_q <= 12'h000;
			trig_prev_q <= 12'h000;
		end else begin
			trig_meta_q <= trig_pins;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
		end
	end

	assign trig_rise = trig_sync_q & ~trig_prev_q;

	reg trig_hit;
	reg trig_bad;
	always @* begin
		trig_hit = 1'b0;
		trig_bad = 1'b0;
		case (trigger_source_code)
			`TRG_T1_CC1: trig_hit = trig_rise[0];
			`TRG_T1_CC2: trig_hit = trig_rise[1];
			`TRG_T1_CC3: trig_hit = trig_rise[2];
			`TRG_T2_CC2: trig_hit = trig_rise[5];
			`TRG_T1_CC45: trig_hit = trig_rise[3] | trig_rise[4];
			`TRG_EXT_11: trig_hit = trig_rise[10];
			`TRG_T1_TRGO: trig_hit = trig_rise[8];
			// Ambiguous code resolved to the timer-13 compare
			`TRG_T13_CC1: trig_hit = trig_rise[6];
			`TRG_T14_CC1: trig_hit = trig_rise[7];
			`TRG_T2_TRGO: trig_hit = trig_rise[9];
			`TRG_EXT_15: trig_hit = trig_rise[11];
			`TRG_T1_CC4: trig_hit = trig_rise[3];
			`TRG_T1_CC5: trig_hit = trig_rise[4];
			default: trig_bad = 1'b1;
		endcase
	end

	// ==========================================
	// Outputs to the sequencer and the system
	wire [10:0] mask_bits;
	assign mask_bits = channel_enable_mask_q[10:0];

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hw_trigger_out <= 1'b0;
			dma_request_out <= 1'b0;
			irq_out <= 1'b0;
			channel_enable_out <= 11'h001;
			scan_direction_out <= 1'b0;
			trigger_code_invalid_out <= 1'b0;
		end else begin
			hw_trigger_out <= control_q[`CTL_TRG_EN] & trig_hit;
			dma_request_out <= control_q[`CTL_DMA_EN] & conv_done_in;
			irq_out <= (eos_flag & control_q[`CTL_EOS_IE]) |
				(awd_flag & control_q[`CTL_AWD_IE]);
			// An empty mask falls back to channel zero
			channel_enable_out <= (mask_bits == 11'h000) ? 11'h001 : mask_bits;
			scan_direction_out <= control_q[`CTL_SCAN_DIR];
			trigger_code_invalid_out <= trig_bad;
		end
	end

endmodule // adc_cfg_top

// ---- hw/sticky_flag.v ----
// Sticky hardware flag with clear, set winning over clear
`timescale 1ns/1ps
module sticky_flag (
	input wire clk_in,
	input wire rst_n_in,
	input wire set_in,
	input wire clear_in,
	output reg flag_out
);

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_out <= 1'b0;
		end else if (set_in) begin
			// A new event in the clearing cycle must not be lost
			flag_out <= 1'b1;
		end else if (clear_in) begin
			flag_out <= 1'b0;
		end
	end

endmodule // sticky_flag

// ---- pkg/adc_cfg_regs.vh ----
// Register map, field positions and codes of the converter configuration block
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// ==========================================
// Offsets (byte addresses)
`define OFF_CONTROL 8'h08
`define OFF_CHANNEL_ENABLE_MASK 8'h0c
`define OFF_WATCHDOG_THRESHOLDS 8'h10
`define OFF_CONVERSION_STATUS 8'h14

// ==========================================
// Writable bits and reset values
`define CONTROL_WMASK 32'h0007f07f
`define MASK_WMASK 32'h000007ff
`define THRESH_WMASK 32'h0fff0fff
`define CONTROL_RESET 32'h00000000
`define MASK_RESET 32'h00000000
`define THRESH_RESET 32'h00000000

// ==========================================
// Field positions
`define CTL_EOS_IE 0
`define CTL_AWD_IE 1
`define CTL_TRG_EN 2
`define CTL_DMA_EN 3
`define CTL_SEL_LO_MSB 6
`define CTL_SEL_LO_LSB 4
`define CTL_WATCHDOG_CHANNEL_SELECT_MSB 15
`define CTL_WATCHDOG_CHANNEL_SELECT_LSB 12
`define CTL_SCAN_DIR 16
`define CTL_SEL_HI_MSB 18
`define CTL_SEL_HI_LSB 17
`define STA_EOS 0
`define STA_AWD 1

// ==========================================
// Trigger source codes
`define TRG_T1_CC1 5'h00
`define TRG_T1_CC2 5'h01
`define TRG_T1_CC3 5'h02
`define TRG_T2_CC2 5'h03
`define TRG_T1_CC45 5'h05
`define TRG_EXT_11 5'h07
`define TRG_T1_TRGO 5'h08
`define TRG_T13_CC1 5'h09
`define TRG_T14_CC1 5'h0a
`define TRG_T2_TRGO 5'h0d
`define TRG_EXT_15 5'h0f
`define TRG_T1_CC4 5'h10
`define TRG_T1_CC5 5'h11

// ==========================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
